// [hw/direction_tracker.sv]
`timescale 1ns/1ps
`default_nettype none
module direction_tracker (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst_b,
	// Modes
	input wire logic [1:0] posMode,
	input wire logic [1:0] revMode,
	// Counting events
	input wire logic posStep,
	input wire logic posStepDown,
	input wire logic wrap,
	input wire logic phaseEdge,
	input wire logic indexEdge,
	// Results
	output logic lastStepDir,
	output logic lastWrapDir,
	output logic reversalEvent,
	output logic indexResetPos,
	output logic revInhibit
);

	logic modeOn;
	logic dirKnown;
	logic phaseSeen;
	logic earlyIndex;

	assign modeOn = posMode != quad_match_pkg::MODE_OFF;
	assign earlyIndex = indexEdge && modeOn && !phaseSeen;

	// Mode 00 forgets the direction, so the first later step only learns.
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			dirKnown <= 1'b0;
			phaseSeen <= 1'b0;
		end else if (!modeOn) begin
			dirKnown <= 1'b0;
			phaseSeen <= 1'b0;
		end else begin
			dirKnown <= dirKnown | posStep;
			phaseSeen <= phaseSeen | phaseEdge;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			lastStepDir <= 1'b0;
			lastWrapDir <= 1'b0;
		end else begin
			if (posStep && modeOn) begin
				lastStepDir <= posStepDown;
			end
			if (wrap) begin
				lastWrapDir <= posStepDown;
			end
		end
	end

	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			reversalEvent <= 1'b0;
			indexResetPos <= 1'b0;
			revInhibit <= 1'b0;
		end else begin
			reversalEvent <= posStep && modeOn && dirKnown &&
				(posStepDown != lastStepDir);
			indexResetPos <= earlyIndex &&
				(revMode != quad_match_pkg::REV_MODE2);
			revInhibit <= earlyIndex;
		end
	end

endmodule // direction_tracker
`default_nettype wire

// [hw/dual_match_detect.sv]
`timescale 1ns/1ps
`default_nettype none
module dual_match_detect (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst_b,
	// Counter state
	input wire logic [15:0] posCount,
	input wire logic [15:0] posCompare,
	input wire logic [15:0] revCount,
	input wire logic [15:0] revCompare,
	input wire logic [1:0] posMode,
	input wire logic [1:0] revMode,
	// Register write strobes
	input wire logic posCountWr,
	input wire logic posCompareWr,
	input wire logic revCompareWr,
	// Event
	output logic dualSet
);

	logic qualified;
	logic prevQualified;
	logic anyWrite;

	// The role select never enters here, so both compare roles count.
	assign qualified = (posMode != quad_match_pkg::MODE_OFF) &&
		(revMode != quad_match_pkg::MODE_OFF) &&
		(posCount == posCompare) && (revCount == revCompare);
	assign anyWrite = posCountWr | posCompareWr | revCompareWr;

	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			prevQualified <= 1'b0;
		end else begin
			prevQualified <= qualified;
		end
	end

	// A fresh match, a mode leaving 00, or a write that keeps a match.
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			dualSet <= 1'b0;
		end else begin
			dualSet <= qualified && (!prevQualified || anyWrite);
		end
	end

endmodule // dual_match_detect
`default_nettype wire

// [hw/quad_match_pkg.sv]
// Behaviour
// - Bits 15:14 read zero; software writes zero.
// - Dual flag sets on position and revolution match.
// - Writing zero clears flag; writing one ignored.
// - Flags read one during read-modify-write.
// - Position mode leaving 00 with matches sets flag.
// - Position count or compare write match sets flag.
// - Revolution compare write match sets flag.
// - Revolution mode leaving 00 with matches sets flag.
// - Dual flag ignores compare role select.
// - Dual enable gates dual flag onto request.
// - Bit 11 holds direction at last wrap.
// - Bit 10 holds direction of last step.
// - Index before phase edge resets position counter, except in revolution mode 10.
// - That index edge leaves revolution counter unchanged.
// - Direction reversal sets reversal flag.
// - First reversal after mode 00 sets nothing.
// - Reversal enable gates reversal flag onto request.
// - Maximum position register, 16 bits, resets FFFF.
// - Count up at maximum flags overflow.
// - Underflow flags and reloads maximum position.
// - Count down at zero is underflow.
package quad_match_pkg;

	// ----------------------------------------------------------------
	// Register map
	// ----------------------------------------------------------------
	localparam logic [3:0] ADDR_ICTRL = 4'h0;
	localparam logic [3:0] ADDR_MAXPOS = 4'h4;

	// ----------------------------------------------------------------
	// Field positions within the interrupt control word
	// ----------------------------------------------------------------
	localparam int BIT_DUAL_FLAG = 13;
	localparam int BIT_DUAL_EN = 12;
	localparam int BIT_REV_FLAG = 9;
	localparam int BIT_REV_EN = 8;

	// ----------------------------------------------------------------
	// Reset values and constants
	// ----------------------------------------------------------------
	localparam logic [15:0] MAXPOS_RESET = 16'hFFFF;
	localparam logic [15:0] POS_ZERO = 16'h0000;
	localparam logic [1:0] RESERVED_VAL = 2'h0;
	localparam logic [7:0] LOW_BYTE_VAL = 8'h00;
	localparam logic [15:0] HIGH_HALF_VAL = 16'h0000;
	localparam logic [31:0] UNMAPPED_VAL = 32'h00000000;

	// ----------------------------------------------------------------
	// Counter modes
	// ----------------------------------------------------------------
	localparam logic [1:0] MODE_OFF = 2'h0;
	localparam logic [1:0] REV_MODE2 = 2'h2;

endpackage

// [hw/quad_position_match_direction_ctrl.sv]
`timescale 1ns/1ps
`default_nettype none
module quad_position_match_direction_ctrl (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst_b,
	// Wishbone slave
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic lock_i,
	input wire logic [3:0] adr_i,
	input wire logic [3:0] sel_i,
	input wire logic [31:0] dat_i,
	output logic [31:0] dat_o,
	output logic ack_o,
	// Counter state
	input wire logic [15:0] posCount,
	input wire logic [15:0] posCompare,
	input wire logic [15:0] revCount,
	input wire logic [15:0] revCompare,
	input wire logic [1:0] posMode,
	input wire logic [1:0] revMode,
	// Counting events
	input wire logic posStep,
	input wire logic posStepDown,
	input wire logic phaseEdge,
	input wire logic indexEdge,
	// Write strobes of the outer compare and count registers
	input wire logic posCountWr,
	input wire logic posCompareWr,
	input wire logic revCompareWr,
	// Position counter control
	output logic posLoad,
	output logic [15:0] posLoadValue,
	output logic overflowSet,
	output logic underflowSet,
	output logic indexResetPos,
	output logic revInhibit,
	// Interrupt requests
	output logic dualMatchIrq,
	output logic reversalIrq
);

	// ----------------------------------------------------------------
	// Bus decode
	// ----------------------------------------------------------------
	logic req;
	logic hitIctrl;
	logic hitMax;
	logic wrIctrl;
	logic wrMax;

	assign req = cyc_i && stb_i && !ack_o;
	assign hitIctrl = adr_i == quad_match_pkg::ADDR_ICTRL;
	assign hitMax = adr_i == quad_match_pkg::ADDR_MAXPOS;
	assign wrIctrl = req && we_i && hitIctrl && sel_i[1];
	// A byte lane alone cannot update the limit; both low lanes must be set.
	assign wrMax = req && we_i && hitMax && (sel_i[1:0] == 2'h3);

	// ----------------------------------------------------------------
	// Register storage
	// ----------------------------------------------------------------
	logic [15:0] maxPosition;
	logic dualFlag;
	logic dualEn;
	logic revFlag;
	logic revEn;
	logic next_dualFlag;
	logic next_dualEn;
	logic next_revFlag;
	logic next_revEn;
	logic dualSet;
	logic reversalEvent;
	logic lastStepDir;
	logic lastWrapDir;

	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			maxPosition <= quad_match_pkg::MAXPOS_RESET;
		end else if (wrMax) begin
			maxPosition <= dat_i[15:0];
		end
	end

	// A set arriving with a clearing write wins, so no event is lost.
	always_comb begin
		next_dualFlag = dualFlag;
		next_revFlag = revFlag;
		next_dualEn = dualEn;
		next_revEn = revEn;
		if (wrIctrl) begin
			if (!dat_i[quad_match_pkg::BIT_DUAL_FLAG]) begin
				next_dualFlag = 1'b0;
			end
			if (!dat_i[quad_match_pkg::BIT_REV_FLAG]) begin
				next_revFlag = 1'b0;
			end
			next_dualEn = dat_i[quad_match_pkg::BIT_DUAL_EN];
			next_revEn = dat_i[quad_match_pkg::BIT_REV_EN];
		end
		if (dualSet) begin
			next_dualFlag = 1'b1;
		end
		if (reversalEvent) begin
			next_revFlag = 1'b1;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			dualFlag <= 1'b0;
			revFlag <= 1'b0;
			dualEn <= 1'b0;
			revEn <= 1'b0;
		end else begin
			dualFlag <= next_dualFlag;
			revFlag <= next_revFlag;
			dualEn <= next_dualEn;
			revEn <= next_revEn;
		end
	end

	// Built from next values so each request equals flag AND enable now.
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			dualMatchIrq <= 1'b0;
			reversalIrq <= 1'b0;
		end else begin
			dualMatchIrq <= next_dualFlag && next_dualEn;
			reversalIrq <= next_revFlag && next_revEn;
		end
	end

	// ----------------------------------------------------------------
	// Bus answer
	// ----------------------------------------------------------------
	logic [7:0] ictrlByte;
	logic [31:0] next_datO;

	// While lock is held the access is a read-modify-write: flags read one.
	assign ictrlByte = {quad_match_pkg::RESERVED_VAL,
		dualFlag | lock_i, dualEn, lastWrapDir, lastStepDir,
		revFlag | lock_i, revEn};

	always_comb begin
		next_datO = quad_match_pkg::UNMAPPED_VAL;
		if (hitIctrl) begin
			next_datO = {quad_match_pkg::HIGH_HALF_VAL, ictrlByte,
				quad_match_pkg::LOW_BYTE_VAL};
		end else if (hitMax) begin
			next_datO = {quad_match_pkg::HIGH_HALF_VAL, maxPosition};
		end
	end

	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			ack_o <= 1'b0;
			dat_o <= quad_match_pkg::UNMAPPED_VAL;
		end else begin
			ack_o <= req;
			if (req && !we_i) begin
				dat_o <= next_datO;
			end
		end
	end

	// ----------------------------------------------------------------
	// Overflow and underflow
	// ----------------------------------------------------------------
	logic modeOn;
	logic stepUp;
	logic stepDown;
	logic isOverflow;
	logic isUnderflow;

	assign modeOn = posMode != quad_match_pkg::MODE_OFF;
	assign stepUp = posStep && modeOn && !posStepDown;
	assign stepDown = posStep && modeOn && posStepDown;
	assign isOverflow = stepUp && (posCount == maxPosition);
	assign isUnderflow = stepDown &&
		(posCount == quad_match_pkg::POS_ZERO);

	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			overflowSet <= 1'b0;
			underflowSet <= 1'b0;
			posLoad <= 1'b0;
			posLoadValue <= quad_match_pkg::POS_ZERO;
		end else begin
			overflowSet <= isOverflow;
			underflowSet <= isUnderflow;
			posLoad <= isOverflow || isUnderflow;
			if (isOverflow) begin
				posLoadValue <= quad_match_pkg::POS_ZERO;
			end else if (isUnderflow) begin
				posLoadValue <= maxPosition;
			end
		end
	end

	// ----------------------------------------------------------------
	// Match detection and direction tracking
	// ----------------------------------------------------------------
	dual_match_detect u_match (
		.ref_clk(ref_clk),
		.rst_b(rst_b),
		.posCount(posCount),
		.posCompare(posCompare),
		.revCount(revCount),
		.revCompare(revCompare),
		.posMode(posMode),
		.revMode(revMode),
		.posCountWr(posCountWr),
		.posCompareWr(posCompareWr),
		.revCompareWr(revCompareWr),
		.dualSet(dualSet)
	);

	direction_tracker u_dir (
		.ref_clk(ref_clk),
		.rst_b(rst_b),
		.posMode(posMode),
		.revMode(revMode),
		.posStep(posStep),
		.posStepDown(posStepDown),
		.wrap(isOverflow || isUnderflow),
		.phaseEdge(phaseEdge),
		.indexEdge(indexEdge),
		.lastStepDir(lastStepDir),
		.lastWrapDir(lastWrapDir),
		.reversalEvent(reversalEvent),
		.indexResetPos(indexResetPos),
		.revInhibit(revInhibit)
	);

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!rst_b);

	logic bothMatch;
	logic bothModes;
	assign bothMatch = (posCount == posCompare) && (revCount == revCompare);
	assign bothModes = modeOn && (revMode != quad_match_pkg::MODE_OFF);

	a_reserved_zero: assert property (
		req && !we_i && hitIctrl |=> dat_o[15:14] == 2'h0)
		else $error("reserved bits read nonzero");

	a_dual_fresh: assert property (
		bothModes && bothMatch && !$past(bothModes && bothMatch)
		|-> ##2 dualFlag)
		else $error("dual flag missed a fresh match");

	a_dual_clear: assert property (
		wrIctrl && !dat_i[13] && !dualSet |=> !dualFlag)
		else $error("dual flag not cleared by zero");

	a_dual_keep: assert property (
		wrIctrl && dat_i[13] && dualFlag |=> dualFlag)
		else $error("writing one altered dual flag");

	a_rmw_ones: assert property (
		req && !we_i && hitIctrl && lock_i |=> dat_o[13] && dat_o[9])
		else $error("locked read did not show flags as one");

	a_pos_mode_on: assert property (
		$changed(posMode) && $past(posMode) == 2'h0 && modeOn &&
		revMode != 2'h0 && bothMatch && $stable(posCount) &&
		$stable(posCompare) && $stable(revCount) && $stable(revCompare)
		|-> ##2 dualFlag)
		else $error("position mode enable missed match");

	a_write_match: assert property (
		bothModes && bothMatch && (posCountWr || posCompareWr ||
		revCompareWr) |-> ##2 dualFlag)
		else $error("write creating match missed");

	a_rev_mode_on: assert property (
		$past(revMode) == 2'h0 && revMode != 2'h0 && modeOn &&
		bothMatch && $stable(posCount) && $stable(revCount)
		|-> ##2 dualFlag)
		else $error("revolution mode enable missed match");

	a_dual_irq: assert property (
		dualMatchIrq == (dualFlag && dualEn))
		else $error("dual request not flag and enable");

	a_wrap_dir: assert property (
		isOverflow |=> !lastWrapDir ##0 overflowSet)
		else $error("overflow direction not recorded");

	a_step_dir: assert property (
		stepDown |=> lastStepDir)
		else $error("down step not recorded");

	a_early_index: assert property (
		$past(posMode) == 2'h0 && modeOn && indexEdge && !posStep &&
		!phaseEdge |=> revInhibit && (indexResetPos == (revMode != 2'h2)
		|| $changed(revMode)))
		else $error("early index not handled");

	a_reversal: assert property (
		stepDown ##1 stepUp |-> ##2 revFlag)
		else $error("reversal not flagged");

	a_first_step: assert property (
		!modeOn ##1 (modeOn && !posStep) [*1] ##0 !revFlag ##1
		(stepUp && !revFlag && !wrIctrl) |=> ##1 !revFlag)
		else $error("first step after mode 00 flagged");

	a_rev_irq: assert property (
		reversalIrq == (revFlag && revEn))
		else $error("reversal request not flag and enable");

	a_max_write: assert property (
		wrMax |=> maxPosition == $past(dat_i[15:0]))
		else $error("limit write lost");

	a_overflow: assert property (
		isOverflow |=> overflowSet && posLoad && posLoadValue == 16'h0000)
		else $error("overflow not handled");

	a_underflow: assert property (
		stepDown && posCount == 16'h0000 |=> underflowSet && posLoad &&
		posLoadValue == $past(maxPosition))
		else $error("underflow not handled");

	a_rev_clear: assert property (
		wrIctrl && !dat_i[9] && !reversalEvent |=> !revFlag)
		else $error("reversal flag not cleared by zero");

	a_index_mode: assert property (
		indexResetPos |-> $past(revMode) != 2'h2)
		else $error("position reset in revolution mode 10");

	c_dual_set: cover property (dualSet ##1 dualFlag && dualMatchIrq);
	c_reversal: cover property (reversalEvent ##1 revFlag);
	c_overflow: cover property (overflowSet);
	c_rmw_read: cover property (req && !we_i && lock_i && hitIctrl);
	c_index_ten: cover property (revInhibit && !indexResetPos);

endmodule // quad_position_match_direction_ctrl
`default_nettype wire

// [verif/quad_encoder_model.sv]
`timescale 1ns/1ps
`default_nettype none
module quad_encoder_model (
	// Clock
	input wire logic ref_clk,
	// Encoder events
	output logic posStep,
	output logic posStepDown,
	output logic phaseEdge,
	output logic indexEdge
);
	initial begin
		posStep = 1'b0;
		posStepDown = 1'b0;
		phaseEdge = 1'b0;
		indexEdge = 1'b0;
	end

	// ----------------------------------------------------------------
	// Events
	// ----------------------------------------------------------------
	// Between steps the direction line shows the inverse level, so a design
	// that samples it outside a step cannot pass by luck.
	task automatic step(input logic down);
		posStep <= 1'b1;
		phaseEdge <= 1'b1;
		posStepDown <= down;
		@(posedge ref_clk);
		posStep <= 1'b0;
		phaseEdge <= 1'b0;
		posStepDown <= ~down;
	endtask

	// Two steps on consecutive edges, with the strobe held between them.
	task automatic step_pair(input logic first, input logic second);
		posStep <= 1'b1;
		phaseEdge <= 1'b1;
		posStepDown <= first;
		@(posedge ref_clk);
		posStepDown <= second;
		@(posedge ref_clk);
		posStep <= 1'b0;
		phaseEdge <= 1'b0;
		posStepDown <= ~second;
	endtask

	task automatic index();
		indexEdge <= 1'b1;
		@(posedge ref_clk);
		indexEdge <= 1'b0;
	endtask
endmodule // quad_encoder_model
`default_nettype wire

// [verif/test_quad_position_match_direction_ctrl.sv]
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, exp, got) begin cmp_count++; if ((got) !== (exp)) begin \
error_cnt++; $display("unexpected %s: expected %h seen %h", nm, exp, got); \
end end
module test_quad_position_match_direction_ctrl;
	// ----------------------------------------------------------------
	// Signals
	// ----------------------------------------------------------------
	logic ref_clk, rst_b, cyc_i, stb_i, we_i, lock_i, ack_o;
	logic [3:0] adr_i, sel_i;
	logic [31:0] dat_i, dat_o, rd;
	logic [15:0] posCount, posCompare, revCount, revCompare, posLoadValue;
	logic [1:0] posMode, revMode;
	logic posStep, posStepDown, phaseEdge, indexEdge;
	logic posCountWr, posCompareWr, revCompareWr;
	logic posLoad, overflowSet, underflowSet, indexResetPos, revInhibit;
	logic dualMatchIrq, reversalIrq;
	int error_cnt, cmp_count;
	typedef struct packed {
		logic w;
		logic [3:0] a;
		logic [3:0] s;
		logic [31:0] d;
		logic [31:0] e;
	} row_t;
	row_t rows [9];

	quad_position_match_direction_ctrl i_dut (.ref_clk(ref_clk),
		.rst_b(rst_b), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
		.lock_i(lock_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i),
		.dat_o(dat_o), .ack_o(ack_o), .posCount(posCount),
		.posCompare(posCompare), .revCount(revCount),
		.revCompare(revCompare), .posMode(posMode), .revMode(revMode),
		.posStep(posStep), .posStepDown(posStepDown),
		.phaseEdge(phaseEdge), .indexEdge(indexEdge),
		.posCountWr(posCountWr), .posCompareWr(posCompareWr),
		.revCompareWr(revCompareWr), .posLoad(posLoad),
		.posLoadValue(posLoadValue), .overflowSet(overflowSet),
		.underflowSet(underflowSet), .indexResetPos(indexResetPos),
		.revInhibit(revInhibit), .dualMatchIrq(dualMatchIrq),
		.reversalIrq(reversalIrq));

	quad_encoder_model i_enc (.ref_clk(ref_clk), .posStep(posStep),
		.posStepDown(posStepDown), .phaseEdge(phaseEdge),
		.indexEdge(indexEdge));

	initial begin
		ref_clk = 1'b0;
		forever #20 ref_clk = ~ref_clk;
	end

	// ----------------------------------------------------------------
	// Tasks
	// ----------------------------------------------------------------
	task automatic finish_test();
		$display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
		if (error_cnt == 0 && cmp_count > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	// Entered just after a rising edge; returns just after one.
	task automatic wb(input logic w, input logic [3:0] a,
		input logic [3:0] s, input logic [31:0] d, input logic lk,
		output logic [31:0] q);
		int n;
		n = 0;
		cyc_i <= 1'b1;
		stb_i <= 1'b1;
		we_i <= w;
		adr_i <= a;
		sel_i <= s;
		dat_i <= d;
		lock_i <= lk;
		do begin
			@(posedge ref_clk);
			n++;
		end while (ack_o !== 1'b1 && n < 20);
		q = dat_o;
		if (n >= 20) begin
			error_cnt++;
			$display("unexpected ack: none within 20 cycles");
		end
		cyc_i <= 1'b0;
		stb_i <= 1'b0;
		we_i <= 1'b0;
		lock_i <= 1'b0;
		@(posedge ref_clk);
	endtask

	initial begin
		repeat (3000) @(posedge ref_clk);
		error_cnt++;
		finish_test();
	end

	// ----------------------------------------------------------------
	// Sequence
	// ----------------------------------------------------------------
	initial begin
		{cyc_i, stb_i, we_i, lock_i, adr_i, sel_i, dat_i} = '0;
		{posCountWr, posCompareWr, revCompareWr} = 3'h0;
		posMode = 2'h1;
		revMode = 2'h1;
		posCount = 16'h0000;
		revCount = 16'h0000;
		posCompare = 16'h0005;
		revCompare = 16'h0007;
		error_cnt = 0;
		cmp_count = 0;
		rst_b = 1'b0;
		// Software keeps full 16-bit lanes on the limit register.
		rows = '{'{1'b0, 4'h0, 4'hF, 32'h0, 32'h0},
			'{1'b0, 4'h4, 4'hF, 32'h0, 32'h0000FFFF},
			'{1'b0, 4'h8, 4'hF, 32'h0, 32'h0},
			'{1'b1, 4'h4, 4'h3, 32'h00000010, 32'h0},
			'{1'b0, 4'h4, 4'hF, 32'h0, 32'h00000010},
			'{1'b1, 4'h0, 4'h2, 32'h00001100, 32'h0},
			'{1'b0, 4'h0, 4'hF, 32'h0, 32'h00001100},
			'{1'b1, 4'h8, 4'hF, 32'hFFFFFFFF, 32'h0},
			'{1'b0, 4'h8, 4'hF, 32'h0, 32'h0}};
		repeat (3) @(posedge ref_clk);
		rst_b <= 1'b1;
		@(posedge ref_clk);
		foreach (rows[i]) begin
			wb(rows[i].w, rows[i].a, rows[i].s, rows[i].d, 1'b0, rd);
			if (!rows[i].w) `CHK("register", rows[i].e, rd)
		end
		// Wrap at the limit, both ways.
		posCount <= 16'h0010;
		@(posedge ref_clk);
		i_enc.step(1'b0);
		#1;
		`CHK("ovf", 3'h6, {overflowSet, posLoad, underflowSet})
		`CHK("ovf load", 16'h0000, posLoadValue)
		@(posedge ref_clk);
		wb(1'b0, 4'h0, 4'hF, 32'h0, 1'b0, rd);
		`CHK("wrap dir up", 1'b0, rd[11])
		posCount <= 16'h0000;
		@(posedge ref_clk);
		i_enc.step(1'b1);
		#1;
		`CHK("unf", 3'h6, {underflowSet, posLoad, overflowSet})
		`CHK("unf load", 16'h0010, posLoadValue)
		@(posedge ref_clk);
		wb(1'b0, 4'h0, 4'hF, 32'h0, 1'b0, rd);
		`CHK("dirs", 2'h3, rd[11:10])
		wb(1'b1, 4'h0, 4'h2, 32'h1100, 1'b0, rd);
		// First step after disabling forgets the old direction.
		posMode <= 2'h0;
		@(posedge ref_clk);
		posMode <= 2'h1;
		@(posedge ref_clk);
		i_enc.step(1'b0);
		repeat (3) @(posedge ref_clk);
		`CHK("no reversal", 1'b0, reversalIrq)
		i_enc.step_pair(1'b1, 1'b0);
		repeat (3) @(posedge ref_clk);
		`CHK("reversal irq", 1'b1, reversalIrq)
		wb(1'b1, 4'h0, 4'h2, 32'h3300, 1'b0, rd);
		wb(1'b0, 4'h0, 4'hF, 32'h0, 1'b0, rd);
		`CHK("write one", 32'h00001B00, rd)
		wb(1'b0, 4'h0, 4'hF, 32'h0, 1'b1, rd);
		`CHK("rmw read", 32'h00003B00, rd)
		wb(1'b1, 4'h0, 4'h2, 32'h1100, 1'b0, rd);
		repeat (2) @(posedge ref_clk);
		`CHK("cleared", 1'b0, reversalIrq)
		// Index before any phase edge, then after one.
		posMode <= 2'h0;
		@(posedge ref_clk);
		posMode <= 2'h1;
		i_enc.index();
		#1;
		`CHK("early idx", 2'h3, {indexResetPos, revInhibit})
		@(posedge ref_clk);
		revMode <= 2'h2;
		i_enc.index();
		#1;
		`CHK("idx mode 10", 2'h1, {indexResetPos, revInhibit})
		@(posedge ref_clk);
		revMode <= 2'h1;
		i_enc.step(1'b0);
		i_enc.index();
		#1;
		`CHK("late idx", 2'h0, {indexResetPos, revInhibit})
		@(posedge ref_clk);
		// Both compares matching.
		posCount <= 16'h0005;
		revCount <= 16'h0007;
		repeat (4) @(posedge ref_clk);
		`CHK("dual", 1'b1, dualMatchIrq)
		wb(1'b1, 4'h0, 4'h2, 32'h1100, 1'b0, rd);
		repeat (3) @(posedge ref_clk);
		`CHK("dual clr", 1'b0, dualMatchIrq)
		for (int k = 0; k < 5; k++) begin
			if (k == 0) posMode <= 2'h0;
			if (k == 1) revMode <= 2'h0;
			@(posedge ref_clk);
			wb(1'b1, 4'h0, 4'h2, 32'h1100, 1'b0, rd);
			posMode <= 2'h1;
			revMode <= 2'h1;
			posCountWr <= (k == 2);
			posCompareWr <= (k == 3);
			revCompareWr <= (k == 4);
			@(posedge ref_clk);
			{posCountWr, posCompareWr, revCompareWr} <= 3'h0;
			repeat (3) @(posedge ref_clk);
			`CHK("dual event", 1'b1, dualMatchIrq)
		end
		wb(1'b1, 4'h0, 4'h2, 32'h0100, 1'b0, rd);
		posCompareWr <= 1'b1;
		@(posedge ref_clk);
		posCompareWr <= 1'b0;
		repeat (3) @(posedge ref_clk);
		`CHK("dual masked", 1'b0, dualMatchIrq)
		wb(1'b1, 4'h0, 4'h2, 32'h2100, 1'b0, rd);
		wb(1'b0, 4'h0, 4'hF, 32'h0, 1'b0, rd);
		`CHK("dual flag", 32'h00002900, rd)
		// A reset in mid-run must drop flags, enables and the limit.
		posCount <= 16'h0000;
		rst_b <= 1'b0;
		@(posedge ref_clk);
		rst_b <= 1'b1;
		@(posedge ref_clk);
		`CHK("reset irq", 2'h0, {dualMatchIrq, reversalIrq})
		wb(1'b0, 4'h0, 4'hF, 32'h0, 1'b0, rd);
		`CHK("reset ctrl", 32'h0, rd)
		wb(1'b0, 4'h4, 4'hF, 32'h0, 1'b0, rd);
		`CHK("reset limit", 32'h0000FFFF, rd)
		finish_test();
	end
endmodule // test_quad_position_match_direction_ctrl
`default_nettype wire
